// ### core/timer16_control_capture_regs.sv
//----------------------------------------
// Purpose: 16-bit timer with prescaler, capture, compare and force strobes
// Assumes: ref_clk 20 MHz is the I/O clock; pins are asynchronous
// Notes: counting is single slope up to the mode top in every mode
//----------------------------------------
// How it works
// - with filter on, filtered input moves after four equal samples
// - filter adds four cycles of delay to capture recognition
// - edge select zero captures falling edge, one captures rising edge
// - capture copies count into capture value and sets capture flag
// - modes using capture value as top disable input capture
// - clock code 000 stops, 001..101 divide by 1,8,64,256,1024
// - codes 110 and 111 count falling or rising external pin edges
// - external pin counts even when driven as output
// - force bits act only in non-PWM modes
// - force applies immediate match using output action field
// - forced match sets no flag and clears no counter
// - force bits are strobes and read back zero
// - one shared high-byte latch makes 16-bit access atomic
// - count write blocks compare match on next timer clock
// - compare values continuously compared with count
// - capture source is the pin or the analog comparator
// - capture irq needs enable, global flag and capture flag
// - unused mask bits read zero
// - actions: 00 port, 01 toggle, 10 clear, 11 set
// - capture flag clears on vector ack or writing one
`timescale 1ns/100ps
module timer16_control_capture_regs (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic capture_input_pin,
	input wire logic analog_comp_out,
	input wire logic external_count_pin,
	input wire logic global_irq_enable,
	input wire logic capture_irq_ack,
	output logic capture_irq_req,
	output logic waveform_out_a,
	output logic waveform_out_a_en,
	output logic waveform_out_b,
	output logic waveform_out_b_en
);
	//----------------------------------------
	// registers
	//----------------------------------------
	timer16_pkg::ctrl_a_t ctrl_a_ff;
	timer16_pkg::ctrl_b_t ctrl_b_ff;
	logic [7:0] irq_mask_ff;
	logic [7:0] flags_ff;
	logic [7:0] temp_ff;
	logic [7:0] rdata_ff;
	logic [15:0] count_ff;
	logic [15:0] cmp_a_ff;
	logic [15:0] cmp_b_ff;
	logic [15:0] capt_ff;
	logic [timer16_pkg::PRESC_W-1:0] presc_ff;
	logic block_ff;
	logic wave_a_ff;
	logic wave_b_ff;
	logic [1:0] cap_pin_sync_ff;
	logic [1:0] cmp_sync_ff;
	logic [2:0] ext_sync_ff;
	logic [timer16_pkg::FILTER_SAMPLES-2:0] hist_ff;
	logic filt_ff;
	logic cap_prev_ff;

	//----------------------------------------
	// register decode
	//----------------------------------------
	wire wr_mask = reg_wr && reg_addr == timer16_pkg::OFF_IRQ_MASK;
	wire wr_flags = reg_wr && reg_addr == timer16_pkg::OFF_FLAGS;
	wire wr_ctrl_a = reg_wr && reg_addr == timer16_pkg::OFF_CTRL_A;
	wire wr_ctrl_b = reg_wr && reg_addr == timer16_pkg::OFF_CTRL_B;
	wire wr_ctrl_c = reg_wr && reg_addr == timer16_pkg::OFF_CTRL_C;
	wire wr_high = reg_wr && (reg_addr == timer16_pkg::OFF_COUNT_H || reg_addr == timer16_pkg::OFF_CAPT_H
		|| reg_addr == timer16_pkg::OFF_CMPA_H || reg_addr == timer16_pkg::OFF_CMPB_H);
	wire wr_count = reg_wr && reg_addr == timer16_pkg::OFF_COUNT_L;
	wire wr_capt = reg_wr && reg_addr == timer16_pkg::OFF_CAPT_L;
	wire wr_cmp_a = reg_wr && reg_addr == timer16_pkg::OFF_CMPA_L;
	wire wr_cmp_b = reg_wr && reg_addr == timer16_pkg::OFF_CMPB_L;
	wire rd_count_l = reg_rd && reg_addr == timer16_pkg::OFF_COUNT_L;
	wire rd_capt_l = reg_rd && reg_addr == timer16_pkg::OFF_CAPT_L;
	// low-byte write joins the shared latch
	wire [15:0] wr_word = {temp_ff, reg_wdata};

	//----------------------------------------
	// mode decode
	//----------------------------------------
	wire [3:0] wave_mode = {ctrl_b_ff.waveform_mode_hi, ctrl_a_ff.waveform_mode_lo};
	wire non_pwm = wave_mode == 4'h0 || wave_mode == 4'h4 || wave_mode == 4'hc;
	wire ctc_a = wave_mode == 4'h4;
	wire capt_top = wave_mode == 4'h8 || wave_mode == 4'ha || wave_mode == 4'hc || wave_mode == 4'he;
	wire cmpa_top = ctc_a || wave_mode == 4'h9 || wave_mode == 4'hb || wave_mode == 4'hf;
	logic [15:0] top_val;
	always_comb begin
		unique case (wave_mode)
			4'h1, 4'h5: top_val = timer16_pkg::TOP_8BIT;
			4'h2, 4'h6: top_val = timer16_pkg::TOP_9BIT;
			4'h3, 4'h7: top_val = timer16_pkg::TOP_10BIT;
			default: top_val = capt_top ? capt_ff : (cmpa_top ? cmp_a_ff : timer16_pkg::TOP_MAX);
		endcase
	end

	//----------------------------------------
	// timer clock select
	//----------------------------------------
	// pin level is read back regardless of its direction
	wire ext_fall = ext_sync_ff[2] && !ext_sync_ff[1];
	wire ext_rise = !ext_sync_ff[2] && ext_sync_ff[1];
	logic tick;
	always_comb begin
		unique case (ctrl_b_ff.clock_source_select)
			timer16_pkg::CS_STOP: tick = 1'b0;
			timer16_pkg::CS_DIV1: tick = 1'b1;
			timer16_pkg::CS_DIV8: tick = &presc_ff[2:0];
			timer16_pkg::CS_DIV64: tick = &presc_ff[5:0];
			timer16_pkg::CS_DIV256: tick = &presc_ff[7:0];
			timer16_pkg::CS_DIV1024: tick = &presc_ff;
			timer16_pkg::CS_EXT_FALL: tick = ext_fall;
			timer16_pkg::CS_EXT_RISE: tick = ext_rise;
		endcase
	end

	//----------------------------------------
	// compare and capture events
	//----------------------------------------
	wire at_top = count_ff == top_val;
	// continuous compare, blocked after count write
	wire match_a = tick && !block_ff && count_ff == cmp_a_ff;
	wire match_b = tick && !block_ff && count_ff == cmp_b_ff;
	wire ovf_ev = tick && count_ff == timer16_pkg::TOP_MAX;
	wire force_a = wr_ctrl_c && reg_wdata[timer16_pkg::BIT_FORCE_A] && non_pwm;
	wire force_b = wr_ctrl_c && reg_wdata[timer16_pkg::BIT_FORCE_B] && non_pwm;
	// comparator or pin as capture source
	wire cmp_or_pin_s = ctrl_a_ff.capture_source ? cmp_sync_ff[1] : cap_pin_sync_ff[1];
	// four agreeing samples: current plus three held
	wire all_same = (&{hist_ff, cmp_or_pin_s}) || !(|{hist_ff, cmp_or_pin_s});
	// filtered path lags by four samples
	wire cap_level = ctrl_b_ff.capture_filter_enable ? filt_ff : cmp_or_pin_s;
	wire cap_edge = ctrl_b_ff.capture_edge_select ? (cap_level && !cap_prev_ff) : (!cap_level && cap_prev_ff);
	// input disconnected when capture value is top
	wire cap_event = cap_edge && !capt_top;
	wire capt_top_flag = capt_top && tick && at_top;
	wire [7:0] flag_set = {2'b00, cap_event || capt_top_flag, 2'b00, match_b, match_a, ovf_ev};
	wire [7:0] flag_clr = (wr_flags ? reg_wdata : 8'h00) | {2'b00, capture_irq_ack, 5'b0_0000};

	//----------------------------------------
	// read mux
	//----------------------------------------
	logic [7:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			timer16_pkg::OFF_IRQ_MASK: rd_mux = irq_mask_ff & timer16_pkg::MASK_IRQ;
			timer16_pkg::OFF_FLAGS: rd_mux = flags_ff;
			timer16_pkg::OFF_CTRL_A: rd_mux = ctrl_a_ff;
			timer16_pkg::OFF_CTRL_B: rd_mux = ctrl_b_ff;
			timer16_pkg::OFF_CTRL_C: rd_mux = 8'h00;
			timer16_pkg::OFF_COUNT_L: rd_mux = count_ff[7:0];
			timer16_pkg::OFF_CAPT_L: rd_mux = capt_ff[7:0];
			timer16_pkg::OFF_COUNT_H, timer16_pkg::OFF_CAPT_H: rd_mux = temp_ff;
			timer16_pkg::OFF_CMPA_L: rd_mux = cmp_a_ff[7:0];
			timer16_pkg::OFF_CMPA_H: rd_mux = cmp_a_ff[15:8];
			timer16_pkg::OFF_CMPB_L: rd_mux = cmp_b_ff[7:0];
			timer16_pkg::OFF_CMPB_H: rd_mux = cmp_b_ff[15:8];
			default: rd_mux = 8'h00;
		endcase
	end

	// action applied on match or force
	function automatic logic apply_action(input logic cur, input logic [1:0] act);
		unique case (act)
			timer16_pkg::ACT_TOGGLE: apply_action = !cur;
			timer16_pkg::ACT_CLEAR: apply_action = 1'b0;
			timer16_pkg::ACT_SET: apply_action = 1'b1;
			default: apply_action = cur;
		endcase
	endfunction : apply_action

	//----------------------------------------
	// next state
	//----------------------------------------
	logic [15:0] nxt_count;
	logic [7:0] nxt_temp;
	always_comb begin
		nxt_count = count_ff;
		// code 000 gives no tick, count holds
		if (tick) begin
			// count clears on a tick at mode top: compare A in mode 4, capture value in mode c; force never clears
			nxt_count = at_top ? timer16_pkg::RST_REG16 : 16'(count_ff + 16'h0001);
		end
		if (wr_count) begin
			nxt_count = wr_word;
		end
	end
	always_comb begin
		nxt_temp = temp_ff;
		// shared latch filled by high write or low read
		if (wr_high) begin
			nxt_temp = reg_wdata;
		end else if (rd_count_l) begin
			nxt_temp = count_ff[15:8];
		end else if (rd_capt_l) begin
			nxt_temp = capt_ff[15:8];
		end
	end

	//----------------------------------------
	// synchronisers and filter
	//----------------------------------------
	// two stages for capture sources, three for count pin edge: pins are asynchronous to ref_clk
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cap_pin_sync_ff <= 2'h0;
			cmp_sync_ff <= 2'h0;
			ext_sync_ff <= 3'h0;
			hist_ff <= '0;
			filt_ff <= 1'b0;
			cap_prev_ff <= 1'b0;
		end else begin
			cap_pin_sync_ff <= {cap_pin_sync_ff[0], capture_input_pin};
			cmp_sync_ff <= {cmp_sync_ff[0], analog_comp_out};
			ext_sync_ff <= {ext_sync_ff[1:0], external_count_pin};
			hist_ff <= {hist_ff[timer16_pkg::FILTER_SAMPLES-3:0], cmp_or_pin_s};
			// filter output moves on agreement only
			if (all_same) begin
				filt_ff <= cmp_or_pin_s;
			end
			cap_prev_ff <= cap_level;
		end
	end

	//----------------------------------------
	// control registers
	//----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_a_ff <= timer16_pkg::RST_REG8;
			ctrl_b_ff <= timer16_pkg::RST_REG8;
			irq_mask_ff <= timer16_pkg::RST_REG8;
			temp_ff <= timer16_pkg::RST_REG8;
			rdata_ff <= timer16_pkg::RST_REG8;
		end else begin
			if (wr_ctrl_a) begin
				ctrl_a_ff <= reg_wdata & timer16_pkg::MASK_CTRL_A;
			end
			// reserved bit kept zero whatever is written
			if (wr_ctrl_b) begin
				ctrl_b_ff <= reg_wdata & timer16_pkg::MASK_CTRL_B;
			end
			if (wr_mask) begin
				irq_mask_ff <= reg_wdata & timer16_pkg::MASK_IRQ;
			end
			temp_ff <= nxt_temp;
			rdata_ff <= reg_rd ? rd_mux : 8'h00;
		end
	end

	//----------------------------------------
	// counter, compare and capture values
	//----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_ff <= timer16_pkg::RST_REG16;
			cmp_a_ff <= timer16_pkg::RST_REG16;
			cmp_b_ff <= timer16_pkg::RST_REG16;
			capt_ff <= timer16_pkg::RST_REG16;
			presc_ff <= '0;
			block_ff <= 1'b0;
		end else begin
			count_ff <= nxt_count;
			presc_ff <= presc_ff + 1'b1;
			// block armed by count write, spent on next tick
			block_ff <= wr_count || (block_ff && !tick);
			if (wr_cmp_a) begin
				cmp_a_ff <= wr_word;
			end
			if (wr_cmp_b) begin
				cmp_b_ff <= wr_word;
			end
			// capture copies count; event wins over write
			if (cap_event) begin
				capt_ff <= count_ff;
			end else if (wr_capt) begin
				capt_ff <= wr_word;
			end
		end
	end

	//----------------------------------------
	// flags and waveform outputs
	//----------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_ff <= timer16_pkg::RST_REG8;
			wave_a_ff <= 1'b0;
			wave_b_ff <= 1'b0;
		end else begin
			// set wins over clear; force sets no flag
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
			// forced or real match in non-PWM modes
			if ((match_a && non_pwm) || force_a) begin
				wave_a_ff <= apply_action(wave_a_ff, ctrl_a_ff.output_action_a);
			end
			if ((match_b && non_pwm) || force_b) begin
				wave_b_ff <= apply_action(wave_b_ff, ctrl_a_ff.output_action_b);
			end
		end
	end

	assign reg_rdata = rdata_ff;
	assign capture_irq_req = irq_mask_ff[timer16_pkg::BIT_CAPT] && global_irq_enable
		&& flags_ff[timer16_pkg::BIT_CAPT];
	assign waveform_out_a = wave_a_ff;
	assign waveform_out_b = wave_b_ff;
	// code 00 leaves pin to port
	assign waveform_out_a_en = ctrl_a_ff.output_action_a != timer16_pkg::ACT_OFF;
	assign waveform_out_b_en = ctrl_a_ff.output_action_b != timer16_pkg::ACT_OFF;

	//----------------------------------------
	// assertions
	//----------------------------------------
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_filter_agree: assert property (ctrl_b_ff.capture_filter_enable && $changed(filt_ff) |->
		$past(all_same)) else $error("filter moved without four equal samples");
	a_filter_delay: assert property (ctrl_b_ff.capture_filter_enable && $rose(filt_ff) |->
		$past(cmp_or_pin_s, 4)) else $error("filter delay not four cycles");
	a_capture_copy: assert property (cap_event |=> capt_ff == $past(count_ff)
		&& flags_ff[timer16_pkg::BIT_CAPT]) else $error("capture did not copy count");
	a_edge_select: assert property (cap_event |->
		cap_level == ctrl_b_ff.capture_edge_select && $past(cap_level) != cap_level)
		else $error("capture on wrong edge");
	a_capture_off: assert property (capt_top && !wr_capt |=> $stable(capt_ff))
		else $error("capture while capture value is top");
	a_stop_hold: assert property (ctrl_b_ff.clock_source_select == timer16_pkg::CS_STOP && !wr_count
		|=> $stable(count_ff)) else $error("counter moved while stopped");
	a_pwm_force: assert property (wr_ctrl_c && !non_pwm && !match_a |=> $stable(wave_a_ff))
		else $error("force acted in PWM mode");
	a_force_zero: assert property (reg_rd && reg_addr == timer16_pkg::OFF_CTRL_C |=> reg_rdata == 8'h00)
		else $error("force bits read nonzero");
	a_match_block: assert property (wr_count ##1 tick |-> !match_a && !match_b)
		else $error("match after count write");
	a_irq_gate: assert property (capture_irq_req |-> global_irq_enable
		&& irq_mask_ff[timer16_pkg::BIT_CAPT]) else $error("capture irq without enables");
	a_mask_unused: assert property (reg_rd && reg_addr == timer16_pkg::OFF_IRQ_MASK |=>
		reg_rdata[7:6] == 2'b00) else $error("unused mask bits nonzero");
	a_flag_setwins: assert property (cap_event && capture_irq_ack |=> flags_ff[timer16_pkg::BIT_CAPT])
		else $error("capture lost to clear");

	c_capture: cover property (cap_event ##1 capture_irq_req);
	c_force: cover property (force_a ##1 $changed(wave_a_ff));
	c_ext_tick: cover property (ctrl_b_ff.clock_source_select == timer16_pkg::CS_EXT_RISE && tick);
endmodule : timer16_control_capture_regs

// ### core/timer16_pkg.sv
//----------------------------------------
// Purpose: constants and types for timer16_control_capture_regs
// Assumes: 8-bit register port, byte offsets as addresses
// Notes: 16-bit registers use low byte at even offset
//----------------------------------------
package timer16_pkg;
	localparam logic [7:0] OFF_FLAGS = 8'h36;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h6f;
	localparam logic [7:0] OFF_CTRL_A = 8'h80;
	localparam logic [7:0] OFF_CTRL_B = 8'h81;
	localparam logic [7:0] OFF_CTRL_C = 8'h82;
	localparam logic [7:0] OFF_COUNT_L = 8'h84;
	localparam logic [7:0] OFF_COUNT_H = 8'h85;
	localparam logic [7:0] OFF_CAPT_L = 8'h86;
	localparam logic [7:0] OFF_CAPT_H = 8'h87;
	localparam logic [7:0] OFF_CMPA_L = 8'h88;
	localparam logic [7:0] OFF_CMPA_H = 8'h89;
	localparam logic [7:0] OFF_CMPB_L = 8'h8a;
	localparam logic [7:0] OFF_CMPB_H = 8'h8b;
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [15:0] RST_REG16 = 16'h0000;
	// bit positions
	localparam int BIT_CAPT = 5;
	localparam int BIT_CMPB = 2;
	localparam int BIT_CMPA = 1;
	localparam int BIT_OVF = 0;
	localparam int BIT_FORCE_A = 7;
	localparam int BIT_FORCE_B = 6;
	localparam int BIT_CAPT_SRC = 2;
	localparam logic [7:0] MASK_IRQ = 8'h27;
	localparam logic [7:0] MASK_CTRL_B = 8'hdf;
	localparam logic [7:0] MASK_CTRL_A = 8'hf7;
	// clock source codes
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam int PRESC_W = 10;
	localparam int FILTER_SAMPLES = 4;
	localparam logic [15:0] TOP_8BIT = 16'h00ff;
	localparam logic [15:0] TOP_9BIT = 16'h01ff;
	localparam logic [15:0] TOP_10BIT = 16'h03ff;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	// output action codes
	localparam logic [1:0] ACT_OFF = 2'h0;
	localparam logic [1:0] ACT_TOGGLE = 2'h1;
	localparam logic [1:0] ACT_CLEAR = 2'h2;
	localparam logic [1:0] ACT_SET = 2'h3;

	typedef struct packed {
		logic capture_filter_enable;
		logic capture_edge_select;
		logic reserved;
		logic [1:0] waveform_mode_hi;
		logic [2:0] clock_source_select;
	} ctrl_b_t;

	typedef struct packed {
		logic [1:0] output_action_a;
		logic [1:0] output_action_b;
		logic reserved;
		logic capture_source;
		logic [1:0] waveform_mode_lo;
	} ctrl_a_t;
endpackage : timer16_pkg

// ### test/pin_model.sv
//----------------------------------------
// Purpose: far-side pins of the 16-bit timer
// Assumes: levels change just after a ref_clk edge
// Notes: capture sources idle high, count pin idles low
//----------------------------------------
`timescale 1ns/100ps
module pin_model (
	input wire logic ref_clk,
	output logic capture_input_pin,
	output logic analog_comp_out,
	output logic external_count_pin
);
	initial begin
		capture_input_pin = 1'b1;
		analog_comp_out = 1'b1;
		external_count_pin = 1'b0;
	end
	// short hold makes a glitch, long hold a real edge
	task automatic cap_level(input logic lvl, input int hold);
		@(posedge ref_clk);
		capture_input_pin <= lvl;
		repeat (hold) @(posedge ref_clk);
	endtask : cap_level
	task automatic comp_level(input logic lvl, input int hold);
		@(posedge ref_clk);
		analog_comp_out <= lvl;
		repeat (hold) @(posedge ref_clk);
	endtask : comp_level
	// pin driven like an output still clocks
	task automatic count_pulses(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			external_count_pin <= 1'b1;
			repeat (4) @(posedge ref_clk);
			external_count_pin <= 1'b0;
			repeat (3) @(posedge ref_clk);
		end
	endtask : count_pulses
endmodule : pin_model

// ### test/timer16_control_capture_regs_test.sv
//----------------------------------------
// Purpose: self-checking bench for timer16_control_capture_regs
// Assumes: counter stopped unless a test starts it
// Notes: divider counts allow one tick slack, prescaler phase is free
//----------------------------------------
`timescale 1ns/100ps
module timer16_control_capture_regs_test;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp_val;
	} row_t;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic global_irq_enable = 1'b1;
	logic capture_irq_ack = 1'b0;
	logic [7:0] reg_rdata;
	logic capture_irq_req, wa, wa_en, wb, wb_en, cap_pin, comp_pin, cnt_pin;
	int bad_count = 0;
	int n_tests = 0;
	int lat [2];
	int divs [5] = '{1, 8, 64, 256, 1024};
	logic [15:0] v;
	logic eo;
	logic [1:0] acts [5];
	row_t rows [4];
	always #25 ref_clk = ~ref_clk;
	timer16_control_capture_regs timer16_control_capture_regs_inst (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata),
		.capture_input_pin(cap_pin),
		.analog_comp_out(comp_pin),
		.external_count_pin(cnt_pin),
		.global_irq_enable(global_irq_enable),
		.capture_irq_ack(capture_irq_ack),
		.capture_irq_req(capture_irq_req),
		.waveform_out_a(wa),
		.waveform_out_a_en(wa_en),
		.waveform_out_b(wb),
		.waveform_out_b_en(wb_en)
	);
	pin_model pin_model_inst (
		.ref_clk(ref_clk),
		.capture_input_pin(cap_pin),
		.analog_comp_out(comp_pin),
		.external_count_pin(cnt_pin)
	);
	//----------------------------------------
	// helpers
	//----------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		d = reg_rdata;
	endtask : rd
	// high byte first on write, low byte first on read
	task automatic wr16(input logic [7:0] lo, input logic [15:0] d);
		wr(lo + 8'h01, d[15:8]);
		wr(lo, d[7:0]);
	endtask : wr16
	task automatic rd16(input logic [7:0] lo, output logic [15:0] d);
		rd(lo, d[7:0]);
		rd(lo + 8'h01, d[15:8]);
	endtask : rd16
	task automatic chk8(input string what, input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		rd(a, d);
		check(what, {8'h00, d}, {8'h00, exp});
	endtask : chk8
	task automatic chk16(input string what, input logic [7:0] lo, input logic [15:0] exp);
		logic [15:0] d;
		rd16(lo, d);
		check(what, d, exp);
	endtask : chk16
	//----------------------------------------
	// tests
	//----------------------------------------
	initial begin
		rows = '{'{8'h6f, 8'hff, 8'h27}, '{8'h81, 8'hd8, 8'hd8}, '{8'h82, 8'hc0, 8'h00}, '{8'h40, 8'h5a, 8'h00}};
		acts = '{timer16_pkg::ACT_SET, timer16_pkg::ACT_TOGGLE, timer16_pkg::ACT_CLEAR,
			timer16_pkg::ACT_TOGGLE, timer16_pkg::ACT_OFF};
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			chk8("table row", rows[i].addr, rows[i].exp_val);
		end
		$display("register table done");
		wr16(timer16_pkg::OFF_COUNT_L, 16'h1234);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		chk8("mask after reset", timer16_pkg::OFF_IRQ_MASK, timer16_pkg::RST_REG8);
		chk8("ctrl b after reset", timer16_pkg::OFF_CTRL_B, timer16_pkg::RST_REG8);
		chk16("count after reset", timer16_pkg::OFF_COUNT_L, timer16_pkg::RST_REG16);
		$display("reset test done");
		for (int c = 1; c <= 5; c++) begin
			wr16(timer16_pkg::OFF_COUNT_L, 16'h0000);
			wr(timer16_pkg::OFF_CTRL_B, {5'h00, 3'(c)});
			repeat (8 * divs[c - 1] - 2) @(posedge ref_clk);
			wr(timer16_pkg::OFF_CTRL_B, 8'h00);
			rd16(timer16_pkg::OFF_COUNT_L, v);
			check("ticks per divider", 16'(v >= 16'h0007 && v <= 16'h0009), 16'h0001);
		end
		repeat (50) @(posedge ref_clk);
		chk16("stopped count", timer16_pkg::OFF_COUNT_L, v);
		for (int e = 0; e < 2; e++) begin
			wr16(timer16_pkg::OFF_COUNT_L, 16'h0000);
			wr(timer16_pkg::OFF_CTRL_B, {5'h00, e ? timer16_pkg::CS_EXT_RISE : timer16_pkg::CS_EXT_FALL});
			pin_model_inst.count_pulses(5);
			repeat (6) @(posedge ref_clk);
			wr(timer16_pkg::OFF_CTRL_B, 8'h00);
			chk16("external edges", timer16_pkg::OFF_COUNT_L, 16'h0005);
		end
		$display("clock source test done");
		wr(timer16_pkg::OFF_IRQ_MASK, 8'h20);
		for (int s = 0; s < 2; s++) begin
			wr16(timer16_pkg::OFF_COUNT_L, s ? 16'h5678 : 16'h1234);
			wr(timer16_pkg::OFF_CTRL_B, {1'b0, s[0], 6'h00});
			pin_model_inst.cap_level(s[0], 8);
			wr(timer16_pkg::OFF_FLAGS, 8'hff);
			pin_model_inst.cap_level(!s[0], 8);
			chk8("wrong edge flag", timer16_pkg::OFF_FLAGS, 8'h00);
			pin_model_inst.cap_level(s[0], 8);
			chk8("capture flag", timer16_pkg::OFF_FLAGS, 8'h20);
			chk16("captured count", timer16_pkg::OFF_CAPT_L, s ? 16'h5678 : 16'h1234);
			check("irq request", {15'h0000, capture_irq_req}, 16'h0001);
		end
		@(posedge ref_clk);
		global_irq_enable <= 1'b0;
		@(negedge ref_clk);
		check("irq masked globally", {15'h0000, capture_irq_req}, 16'h0000);
		@(posedge ref_clk);
		global_irq_enable <= 1'b1;
		capture_irq_ack <= 1'b1;
		@(posedge ref_clk);
		capture_irq_ack <= 1'b0;
		chk8("flag after ack", timer16_pkg::OFF_FLAGS, 8'h00);
		for (int f = 0; f < 2; f++) begin
			wr(timer16_pkg::OFF_CTRL_B, {f[0], 7'h00});
			pin_model_inst.cap_level(1'b1, 8);
			wr(timer16_pkg::OFF_FLAGS, 8'h20);
			pin_model_inst.cap_level(1'b0, 0);
			lat[f] = 0;
			while (capture_irq_req !== 1'b1 && lat[f] < 30) begin
				@(negedge ref_clk);
				lat[f]++;
			end
		end
		check("filter delay", 16'(lat[1] - lat[0]), 16'h0004);
		pin_model_inst.cap_level(1'b1, 8);
		wr(timer16_pkg::OFF_FLAGS, 8'h20);
		pin_model_inst.cap_level(1'b0, 2);
		pin_model_inst.cap_level(1'b1, 10);
		chk8("glitch filtered", timer16_pkg::OFF_FLAGS, 8'h00);
		wr(timer16_pkg::OFF_CTRL_B, 8'h00);
		wr(timer16_pkg::OFF_CTRL_A, 8'h04);
		wr16(timer16_pkg::OFF_COUNT_L, 16'h0abc);
		pin_model_inst.cap_level(1'b0, 8);
		chk8("pin ignored", timer16_pkg::OFF_FLAGS, 8'h00);
		pin_model_inst.comp_level(1'b0, 8);
		chk16("comparator capture", timer16_pkg::OFF_CAPT_L, 16'h0abc);
		wr(timer16_pkg::OFF_CTRL_A, 8'h00);
		wr(timer16_pkg::OFF_CTRL_B, 8'h18);
		wr16(timer16_pkg::OFF_CAPT_L, 16'hffff);
		pin_model_inst.cap_level(1'b1, 8);
		wr(timer16_pkg::OFF_FLAGS, 8'hff);
		pin_model_inst.cap_level(1'b0, 8);
		chk8("top mode flag", timer16_pkg::OFF_FLAGS, 8'h00);
		chk16("top mode capture", timer16_pkg::OFF_CAPT_L, 16'hffff);
		$display("capture test done");
		wr(timer16_pkg::OFF_CTRL_B, 8'h00);
		wr16(timer16_pkg::OFF_COUNT_L, 16'h0100);
		eo = 1'b0;
		foreach (acts[k]) begin
			wr(timer16_pkg::OFF_CTRL_A, {acts[k], acts[k], 4'h0});
			wr(timer16_pkg::OFF_CTRL_C, 8'hc0);
			if (acts[k] == timer16_pkg::ACT_SET) eo = 1'b1;
			if (acts[k] == timer16_pkg::ACT_CLEAR) eo = 1'b0;
			if (acts[k] == timer16_pkg::ACT_TOGGLE) eo = ~eo;
			repeat (2) @(negedge ref_clk);
			check("output enables", {14'h0000, wa_en, wb_en}, {14'h0000, {2{acts[k] != 2'h0}}});
			if (acts[k] != timer16_pkg::ACT_OFF) check("forced outputs", {14'h0000, wa, wb}, {14'h0000, eo, eo});
		end
		wr(timer16_pkg::OFF_CTRL_A, 8'hf0);
		wr(timer16_pkg::OFF_CTRL_C, 8'hc0);
		wr(timer16_pkg::OFF_CTRL_B, 8'h08);
		wr(timer16_pkg::OFF_CTRL_A, 8'ha1);
		wr(timer16_pkg::OFF_CTRL_C, 8'hc0);
		repeat (2) @(negedge ref_clk);
		check("pwm ignores force", {14'h0000, wa, wb}, 16'h0003);
		// pwm writes keep force bits zero
		wr(timer16_pkg::OFF_CTRL_C, 8'h00);
		wr(timer16_pkg::OFF_CTRL_A, 8'ha0);
		wr16(timer16_pkg::OFF_CMPA_L, 16'h0200);
		wr(timer16_pkg::OFF_CTRL_C, 8'hc0);
		repeat (2) @(negedge ref_clk);
		check("ctc force acts", {14'h0000, wa, wb}, 16'h0000);
		chk16("force keeps count", timer16_pkg::OFF_COUNT_L, 16'h0100);
		chk8("force sets no flag", timer16_pkg::OFF_FLAGS, 8'h00);
		$display("force test done");
		wr(timer16_pkg::OFF_CTRL_B, 8'h00);
		wr(timer16_pkg::OFF_CTRL_A, 8'h00);
		wr16(timer16_pkg::OFF_CMPA_L, 16'h0005);
		chk16("compare readback", timer16_pkg::OFF_CMPA_L, 16'h0005);
		for (int m = 0; m < 2; m++) begin
			wr(timer16_pkg::OFF_FLAGS, 8'hff);
			wr16(timer16_pkg::OFF_COUNT_L, m ? 16'h0003 : 16'h0005);
			wr(timer16_pkg::OFF_CTRL_B, {5'h00, timer16_pkg::CS_DIV1});
			repeat (3) @(posedge ref_clk);
			wr(timer16_pkg::OFF_CTRL_B, 8'h00);
			chk8("match flags", timer16_pkg::OFF_FLAGS, m ? 8'h02 : 8'h00);
		end
		$display("compare test done");
		conclude();
	end
	initial begin
		repeat (60000) @(posedge ref_clk);
		bad_count++;
		$display("watchdog expired");
		conclude();
	end
endmodule : timer16_control_capture_regs_test
